// ### rtl/edmi_params.svh
// Constants for the external data memory interface
`ifndef EDMI_PARAMS_SVH
`define EDMI_PARAMS_SVH
// Register indices; byte address is four times the index
`define EDMI_IDX_TIMING     10'h0A1
`define EDMI_IDX_PAGE       10'h0A2
`define EDMI_IDX_CONFIG     10'h0A3
`define EDMI_IDX_STATUS     10'h0A4
`define EDMI_RST_TIMING     8'hFF
`define EDMI_RST_PAGE       8'h00
`define EDMI_RST_CONFIG     8'h00
`define EDMI_CONFIG_MASK    8'h1F
// Field positions
`define EDMI_SETUP_HI       7
`define EDMI_SETUP_LO       6
`define EDMI_WIDTH_HI       5
`define EDMI_WIDTH_LO       2
`define EDMI_HOLD_HI        1
`define EDMI_HOLD_LO        0
`define EDMI_MUX_BIT        4
`define EDMI_MODE_HI        3
`define EDMI_MODE_LO        2
`define EDMI_ALE_HI         1
`define EDMI_ALE_LO         0
// Split boundary and FINISH counter reload, one less than the cycles after the hold phase
`define EDMI_BOUNDARY       16'h2000
`define EDMI_ONCHIP_MASK    16'h1FFF
`define EDMI_FINISH_CYC     5'h02
`endif

// ### rtl/edmi_pkg.sv
// Types for the external data memory interface
package edmi_pkg;
  typedef enum logic [1:0] {
    EDMI_MODE_ONCHIP = 2'b00,
    EDMI_MODE_SPLIT  = 2'b01,
    EDMI_MODE_BANK   = 2'b10,
    EDMI_MODE_EXT    = 2'b11
  } edmi_mode_t;

  typedef enum logic [2:0] {
    EDMI_ST_IDLE   = 3'b000,
    EDMI_ST_BEGIN  = 3'b001,
    EDMI_ST_ALE_H  = 3'b010,
    EDMI_ST_ALE_L  = 3'b011,
    EDMI_ST_SETUP  = 3'b100,
    EDMI_ST_STROBE = 3'b101,
    EDMI_ST_HOLD   = 3'b110,
    EDMI_ST_FINISH = 3'b111
  } edmi_state_t;

  typedef struct packed {
    logic        wide;
    logic        write;
    logic [15:0] data_pointer;
    logic [7:0]  low_pointer;
    logic [7:0]  wdata;
  } edmi_req_t;

  typedef struct packed {
    logic        offchip;
    logic        drive_hi;
    logic [15:0] addr;
  } edmi_route_t;

  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] width;
    logic [1:0] hold;
    logic [1:0] ale;
    logic       nonmux;
  } edmi_timing_t;
endpackage : edmi_pkg

// ### rtl/edmi_decode.sv
// Address decode for the external move instruction
`timescale 1ns/10ps
`include "edmi_params.svh"
module edmi_decode
  import edmi_pkg::*;
(
  input  edmi_mode_t  mode,
  input  edmi_req_t   req,
  input  wire [7:0]   on_chip_data_ram_page_select,
  output edmi_route_t route
);
  logic [15:0] eff;

  always_comb begin
    eff   = req.wide ? req.data_pointer : {on_chip_data_ram_page_select, req.low_pointer};
    route = '0;
    case (mode)
      EDMI_MODE_ONCHIP: begin
        route.addr = eff & `EDMI_ONCHIP_MASK;
      end
      EDMI_MODE_SPLIT, EDMI_MODE_BANK: begin
        route.offchip  = (eff >= `EDMI_BOUNDARY);
        route.drive_hi = req.wide | (mode == EDMI_MODE_BANK);
        route.addr     = route.offchip ? eff : (eff & `EDMI_ONCHIP_MASK);
      end
      EDMI_MODE_EXT: begin
        route.offchip  = 1'b1;
        route.drive_hi = req.wide;
        route.addr     = req.wide ? req.data_pointer : {8'h00, req.low_pointer};
      end
      default: begin
        route.addr = eff;
      end
    endcase
  end
endmodule : edmi_decode

// ### rtl/edmi_apb_regs.sv
// APB register file for the external data memory interface
`timescale 1ns/10ps
`include "edmi_params.svh"
module edmi_apb_regs
  import edmi_pkg::*;
(
  input  wire         clk_sys,
  input  wire         rstn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  wire  [7:0]  status,
  output logic [7:0]  timing_reg,
  output logic [7:0]  page_reg,
  output logic [7:0]  config_reg
);
  logic [9:0] idx;
  logic       hit;
  logic       wr_ok;
  logic       setup_ph;
  logic [7:0] rd_val;

  assign idx      = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign pready   = 1'b1;
  assign wr_ok    = psel & penable & pwrite & hit & (idx != `EDMI_IDX_STATUS);

  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `EDMI_IDX_TIMING: rd_val = timing_reg;
      `EDMI_IDX_PAGE:   rd_val = page_reg;
      `EDMI_IDX_CONFIG: rd_val = config_reg;
      `EDMI_IDX_STATUS: rd_val = status;
      default:          hit    = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~hit | (pwrite & (idx == `EDMI_IDX_STATUS));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      timing_reg <= `EDMI_RST_TIMING;
      page_reg   <= `EDMI_RST_PAGE;
      config_reg <= `EDMI_RST_CONFIG;
    end else if (wr_ok) begin
      case (idx)
        `EDMI_IDX_TIMING: timing_reg <= pwdata[7:0];
        `EDMI_IDX_PAGE:   page_reg   <= pwdata[7:0];
        `EDMI_IDX_CONFIG: config_reg <= pwdata[7:0] & `EDMI_CONFIG_MASK;
        default:          timing_reg <= timing_reg;
      endcase
    end
  end
endmodule : edmi_apb_regs

// ### rtl/edmi_top.sv
// External data memory interface: decode, bus sequencer and registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "edmi_params.svh"
module edmi_top
  import edmi_pkg::*;
(
  input  wire         clk_sys,
  input  wire         rstn,
  // APB
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Core request for one external move
  input  wire         move_req,
  input  edmi_req_t   move_cmd,
  output logic        move_ready,
  output logic        move_done,
  output logic [7:0]  move_rdata,
  // On-chip data RAM strobe
  output logic        ram_en,
  output logic        ram_we,
  output logic [12:0] ram_addr,
  output logic [7:0]  ram_wdata,
  // Off-chip pins
  output logic        pins_claimed,
  output logic [7:0]  addr_hi_o,
  output logic        addr_hi_oe,
  output logic [7:0]  addr_lo_o,
  output logic        addr_lo_oe,
  output logic [7:0]  data_o,
  output logic        data_oe,
  input  wire  [7:0]  data_i,
  output logic        ale_o,
  output logic        rd_n_o,
  output logic        wr_n_o,
  output logic        ctrl_oe
);
  logic [7:0]   timing_reg;
  logic [7:0]   page_reg;
  logic [7:0]   config_reg;
  logic [7:0]   status;
  edmi_route_t  route;
  edmi_state_t  state_reg;
  edmi_state_t  state_next;
  logic [4:0]   cnt_reg;
  logic [4:0]   cnt_next;
  edmi_timing_t tim_reg;
  logic [15:0]  addr_reg;
  logic         hi_reg;
  logic         write_reg;
  logic [7:0]   wdata_reg;
  logic         last_off_reg;
  logic         accept;
  logic         cnt_zero;
  logic         start;
  logic [15:0]  addr_cur;
  logic         hi_cur;
  logic         write_cur;
  logic [7:0]   wdata_cur;
  logic         nonmux_cur;

  // ---------------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------------
  edmi_apb_regs u_regs (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .status     (status),
    .timing_reg (timing_reg),
    .page_reg   (page_reg),
    .config_reg (config_reg)
  );

  edmi_decode u_decode (
    .mode             (edmi_mode_t'(config_reg[`EDMI_MODE_HI:`EDMI_MODE_LO])),
    .req              (move_cmd),
    .on_chip_data_ram_page_select (page_reg),
    .route            (route)
  );

  assign status     = {5'b00000, move_done, last_off_reg, (state_reg != EDMI_ST_IDLE)};
  assign move_ready = (state_reg == EDMI_ST_IDLE) & ~move_done;
  assign accept     = move_req & move_ready;
  assign cnt_zero   = (cnt_reg == 5'h00);
  // The access being taken, so the first owned cycle never shows the last one
  assign start      = accept & route.offchip;
  assign addr_cur   = start ? route.addr : addr_reg;
  assign hi_cur     = start ? route.drive_hi : hi_reg;
  assign write_cur  = start ? move_cmd.write : write_reg;
  assign wdata_cur  = start ? move_cmd.wdata : wdata_reg;
  assign nonmux_cur = start ? config_reg[`EDMI_MUX_BIT] : tim_reg.nonmux;

  // ---------------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------------
  // Timing is frozen per access so a register write cannot stretch a live strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tim_reg   <= '0;
      addr_reg  <= 16'h0000;
      hi_reg    <= 1'b0;
      write_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (accept && route.offchip) begin
      tim_reg.setup  <= timing_reg[`EDMI_SETUP_HI:`EDMI_SETUP_LO];
      tim_reg.width  <= timing_reg[`EDMI_WIDTH_HI:`EDMI_WIDTH_LO];
      tim_reg.hold   <= timing_reg[`EDMI_HOLD_HI:`EDMI_HOLD_LO];
      tim_reg.ale    <= config_reg[`EDMI_ALE_HI:`EDMI_ALE_LO];
      tim_reg.nonmux <= config_reg[`EDMI_MUX_BIT];
      addr_reg       <= route.addr;
      hi_reg         <= route.drive_hi;
      write_reg      <= move_cmd.write;
      wdata_reg      <= move_cmd.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      last_off_reg <= 1'b0;
    end else if (accept) begin
      last_off_reg <= route.offchip;
    end
  end

  // ---------------------------------------------------------------------
  // On-chip path: one-cycle strobe, done on the next cycle
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ram_en    <= 1'b0;
      ram_we    <= 1'b0;
      ram_addr  <= 13'h0000;
      ram_wdata <= 8'h00;
    end else begin
      ram_en <= accept & ~route.offchip;
      ram_we <= accept & ~route.offchip & move_cmd.write;
      if (accept && !route.offchip) begin
        ram_addr  <= route.addr[12:0];
        ram_wdata <= move_cmd.wdata;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Off-chip sequencer
  // ---------------------------------------------------------------------
  // BEGIN plus FINISH give the fixed four-cycle overhead on top of
  // setup, strobe and hold; multiplexed adds ALE high and low phases
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      EDMI_ST_IDLE: begin
        if (accept && route.offchip) begin
          state_next = EDMI_ST_BEGIN;
          cnt_next   = 5'h00;
        end
      end
      EDMI_ST_BEGIN: begin
        if (!tim_reg.nonmux) begin
          state_next = EDMI_ST_ALE_H;
          cnt_next   = {3'b000, tim_reg.ale};
        end else if (tim_reg.setup != 2'b00) begin
          state_next = EDMI_ST_SETUP;
          cnt_next   = {3'b000, tim_reg.setup - 2'b01};
        end else begin
          state_next = EDMI_ST_STROBE;
          cnt_next   = {1'b0, tim_reg.width};
        end
      end
      EDMI_ST_ALE_H: begin
        if (cnt_zero) begin
          state_next = EDMI_ST_ALE_L;
          cnt_next   = {3'b000, tim_reg.ale};
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      EDMI_ST_ALE_L: begin
        if (!cnt_zero) begin
          cnt_next = cnt_reg - 5'h01;
        end else if (tim_reg.setup != 2'b00) begin
          state_next = EDMI_ST_SETUP;
          cnt_next   = {3'b000, tim_reg.setup - 2'b01};
        end else begin
          state_next = EDMI_ST_STROBE;
          cnt_next   = {1'b0, tim_reg.width};
        end
      end
      EDMI_ST_SETUP: begin
        if (cnt_zero) begin
          state_next = EDMI_ST_STROBE;
          cnt_next   = {1'b0, tim_reg.width};
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      EDMI_ST_STROBE: begin
        if (!cnt_zero) begin
          cnt_next = cnt_reg - 5'h01;
        end else if (tim_reg.hold != 2'b00) begin
          state_next = EDMI_ST_HOLD;
          cnt_next   = {3'b000, tim_reg.hold - 2'b01};
        end else begin
          state_next = EDMI_ST_FINISH;
          cnt_next   = `EDMI_FINISH_CYC;
        end
      end
      EDMI_ST_HOLD: begin
        if (cnt_zero) begin
          state_next = EDMI_ST_FINISH;
          cnt_next   = `EDMI_FINISH_CYC;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      EDMI_ST_FINISH: begin
        if (cnt_zero) begin
          state_next = EDMI_ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: begin
        state_next = EDMI_ST_IDLE;
        cnt_next   = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= EDMI_ST_IDLE;
      cnt_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ---------------------------------------------------------------------
  // Completion and read data
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      move_done <= 1'b0;
    end else begin
      move_done <= ram_en | ((state_reg == EDMI_ST_FINISH) & cnt_zero);
    end
  end

  // Sampled on the edge that ends the strobe; relies on the memory
  // holding data until the strobe is removed
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      move_rdata <= 8'h00;
    end else if (state_reg == EDMI_ST_STROBE && cnt_zero && !write_reg) begin
      move_rdata <= data_i;
    end
  end

  // ---------------------------------------------------------------------
  // Pin drive, all from flops
  // ---------------------------------------------------------------------
  // Outside an off-chip access every enable is low so the port latches own the pins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pins_claimed <= 1'b0;
      addr_hi_oe   <= 1'b0;
      addr_lo_oe   <= 1'b0;
      ctrl_oe      <= 1'b0;
      addr_hi_o    <= 8'h00;
      addr_lo_o    <= 8'h00;
    end else begin
      pins_claimed <= (state_next != EDMI_ST_IDLE);
      ctrl_oe      <= (state_next != EDMI_ST_IDLE);
      addr_hi_oe   <= (state_next != EDMI_ST_IDLE) & hi_cur;
      addr_lo_oe   <= (state_next != EDMI_ST_IDLE) & nonmux_cur;
      addr_hi_o    <= addr_cur[15:8];
      addr_lo_o    <= addr_cur[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ale_o  <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      ale_o  <= (state_next == EDMI_ST_ALE_H);
      rd_n_o <= ~((state_next == EDMI_ST_STROBE) & ~write_reg);
      wr_n_o <= ~((state_next == EDMI_ST_STROBE) & write_reg);
    end
  end

  // Shared lines: low address through the ALE high and low phases, then write data only;
  // reads release the lines for the whole data phase
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      data_o  <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      case (state_next)
        EDMI_ST_ALE_H, EDMI_ST_ALE_L: begin
          data_o  <= addr_reg[7:0];
          data_oe <= 1'b1;
        end
        EDMI_ST_SETUP, EDMI_ST_STROBE, EDMI_ST_HOLD: begin
          data_o  <= wdata_reg;
          data_oe <= write_reg;
        end
        EDMI_ST_BEGIN: begin
          data_o  <= wdata_cur;
          data_oe <= write_cur & nonmux_cur;
        end
        default: begin
          data_o  <= 8'h00;
          data_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule : edmi_top

// ### tb/edmi_props.sv
// Checker for the external bus pins and move completion
`timescale 1ns/10ps
module edmi_props (
  input wire        clk_sys,
  input wire        rstn,
  input logic       move_done,
  input logic [7:0] move_rdata,
  input logic       pins_claimed,
  input logic       addr_hi_oe,
  input logic       addr_lo_oe,
  input logic       data_oe,
  input wire  [7:0] data_i,
  input logic       ale_o,
  input logic       rd_n_o,
  input logic       wr_n_o,
  input logic       ctrl_oe
);
  logic       rd_seen_reg;
  logic [7:0] rd_val_reg;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // Last value on the data lines while the read strobe was low
  always_ff @(posedge clk_sys) begin
    if (!rstn) rd_seen_reg <= 1'b0;
    else if (!rd_n_o) rd_seen_reg <= 1'b1;
    else if (move_done) rd_seen_reg <= 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (!rd_n_o) rd_val_reg <= data_i;
  end

  AST_PINS_RELEASED: assert property (!pins_claimed |-> !(addr_hi_oe || addr_lo_oe || data_oe || ctrl_oe))
    else $error("pin enable active outside an off-chip access");
  AST_READ_NO_DRIVE: assert property (!rd_n_o |-> !data_oe && wr_n_o)
    else $error("data driven during read strobe");
  AST_WRITE_DRIVES: assert property (!wr_n_o |-> data_oe && ctrl_oe)
    else $error("write strobe without data drive");
  AST_STROBE_OWNED: assert property ((!rd_n_o || !wr_n_o || ale_o) |-> pins_claimed)
    else $error("strobe outside an off-chip access");
  AST_ALE_ADDR: assert property (ale_o |-> data_oe && rd_n_o && wr_n_o)
    else $error("latch strobe without address on shared lines");
  AST_ALE_WIDTH: assert property ($rose(ale_o) |-> ##[1:4] !ale_o)
    else $error("latch strobe high too long");
  AST_ALE_LOW_GAP: assert property ($fell(ale_o) |-> rd_n_o && wr_n_o)
    else $error("strobe at latch strobe fall");
  AST_MIN_ACCESS: assert property ($rose(pins_claimed) |-> pins_claimed [*5])
    else $error("off-chip access shorter than five cycles");
  AST_MUX_MIN: assert property ($rose(pins_claimed) && !addr_lo_oe |-> pins_claimed [*7])
    else $error("multiplexed access shorter than seven cycles");
  AST_DONE_ON_RELEASE: assert property ($fell(pins_claimed) |-> move_done)
    else $error("pins released without completion");
  AST_READ_CAPTURE: assert property (move_done && rd_seen_reg |-> move_rdata == rd_val_reg)
    else $error("read data not taken at strobe end");
endmodule : edmi_props

// ### tb/edmi_sram_model.sv
// Behavioural asynchronous parallel memory on the external bus
`timescale 1ns/10ps
module edmi_sram_model (
  input  wire        clk_sys,
  input  wire        slow,
  input  wire  [7:0] addr_hi_o,
  input  wire        addr_hi_oe,
  input  wire  [7:0] addr_lo_o,
  input  wire        addr_lo_oe,
  input  wire  [7:0] data_o,
  input  wire        ale_o,
  input  wire        rd_n_o,
  input  wire        wr_n_o,
  output logic [7:0] data_i
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  latch_reg;
  logic [7:0]  bus_reg = 8'h00;
  logic [4:0]  strobe_cnt = 5'h00;
  logic [15:0] addr;
  logic [15:0] last_addr;
  logic        last_hi_oe;

  // Undriven upper lines sit at the parked port level of all ones
  assign addr = {addr_hi_oe ? addr_hi_o : 8'hFF, addr_lo_oe ? addr_lo_o : latch_reg};
  // Slow part answers from the second strobe cycle; a released bus flips every cycle
  assign data_i = (!rd_n_o && (!slow || strobe_cnt != 5'h00)) ? mem[addr] : ~bus_reg;
  always @(posedge clk_sys) begin
    bus_reg <= data_i;
    if (ale_o) latch_reg <= data_o;
    if (!wr_n_o) mem[addr] <= data_o;
    strobe_cnt <= (!rd_n_o || !wr_n_o) ? strobe_cnt + 5'h01 : 5'h00;
    if (!rd_n_o || !wr_n_o) begin
      last_addr <= addr;
      last_hi_oe <= addr_hi_oe;
    end
  end
endmodule : edmi_sram_model

// ### tb/testbench.sv
// Self-checking testbench for the external data memory interface
`timescale 1ns/10ps
`include "edmi_params.svh"
module testbench import edmi_pkg::*;;
  logic        clk_sys, rstn, psel, penable, pwrite, move_req, slow;
  logic        pready, pslverr, move_ready, move_done, ram_en, ram_we, pins_claimed;
  logic        addr_hi_oe, addr_lo_oe, data_oe, ale_o, rd_n_o, wr_n_o, ctrl_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  move_rdata, ram_wdata, addr_hi_o, addr_lo_o, data_o, data_i, cur_t;
  logic [12:0] ram_addr;
  logic [4:0]  cur_c;
  edmi_req_t   move_cmd;
  int          err_count, checked;

  edmi_top DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .move_req(move_req), .move_cmd(move_cmd),
    .move_ready(move_ready), .move_done(move_done), .move_rdata(move_rdata), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .pins_claimed(pins_claimed), .addr_hi_o(addr_hi_o),
    .addr_hi_oe(addr_hi_oe), .addr_lo_o(addr_lo_o), .addr_lo_oe(addr_lo_oe), .data_o(data_o), .data_oe(data_oe),
    .data_i(data_i), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ctrl_oe(ctrl_oe));
  edmi_sram_model u_mem (.clk_sys(clk_sys), .slow(slow), .addr_hi_o(addr_hi_o), .addr_hi_oe(addr_hi_oe),
    .addr_lo_o(addr_lo_o), .addr_lo_oe(addr_lo_oe), .data_o(data_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .data_i(data_i));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic cfg(input logic [7:0] t, input logic [4:0] c, input logic [7:0] pg);
    logic [7:0] rd;
    logic       e;
    apb(1'b1, `EDMI_IDX_TIMING, t, rd, e);
    apb(1'b1, `EDMI_IDX_PAGE, pg, rd, e);
    apb(1'b1, `EDMI_IDX_CONFIG, {3'b000, c}, rd, e);
    cur_t = t;
    cur_c = c;
  endtask : cfg

  // Setup + strobe + hold + fixed four, plus both latch phases on a shared bus
  function automatic int expn(input logic [7:0] t, input logic [4:0] c);
    return t[7:6] + t[5:2] + 1 + t[1:0] + 4 + (c[4] ? 0 : 2 * (c[1:0] + 1));
  endfunction : expn

  // Write then read back one location and judge routing, timing and pins
  task automatic access(input logic wide, input logic [15:0] dp, input logic [7:0] lp, input logic off,
                        input logic [15:0] ea, input logic hi);
    int          n;
    logic        c;
    logic        h;
    logic        d;
    logic        we;
    logic [12:0] ra;
    logic [7:0]  wd;
    logic [7:0]  rw;
    wd = lp ^ dp[7:0] ^ 8'hA5;
    for (int wr = 1; wr >= 0; wr--) begin
      move_cmd <= '{wide, wr[0], dp, lp, wd};
      move_req <= 1'b1;
      do @(posedge clk_sys); while (move_ready !== 1'b1);
      move_req <= 1'b0;
      n = 0;
      c = 1'b0;
      h = 1'b0;
      d = 1'b0;
      we = 1'b0;
      ra = 13'h0000;
      rw = 8'h00;
      do begin
        @(posedge clk_sys);
        n++;
        c |= pins_claimed;
        h |= addr_hi_oe;
        if (wr == 0 && cur_c[4]) d |= data_oe;
        if (ram_en === 1'b1) begin
          ra = ram_addr;
          we = ram_we;
          rw = ram_wdata;
        end
      end while (move_done !== 1'b1 && n < 200);
      check("pins claimed", c, off);
      check("data driven in read", d, 1'b0);
      if (off) begin
        // Done flop adds one cycle after the last owned cycle
        check("access cycles", n, expn(cur_t, cur_c) + 1);
        check("bus address", u_mem.last_addr, ea);
        check("upper byte driven", u_mem.last_hi_oe, hi);
        check("upper byte enable", h, hi);
        if (wr == 0) check("read data", move_rdata, wd);
      end
      else begin
        check("ram address", ra, ea[12:0]);
        check("ram write", we, wr[0]);
        check("ram cycles", n, 2);
        if (wr == 1) check("ram write data", rw, wd);
      end
    end
  endtask : access

  task automatic reset_values();
    logic [7:0] rd;
    logic       e;
    apb(1'b0, `EDMI_IDX_TIMING, 8'h00, rd, e);
    check("timing reset", rd, 8'hFF);
    apb(1'b0, `EDMI_IDX_PAGE, 8'h00, rd, e);
    check("page reset", rd, 8'h00);
    apb(1'b0, 10'h0C0, 8'h00, rd, e);
    check("unmapped error", e, 1'b1);
    apb(1'b1, `EDMI_IDX_TIMING, 8'h5A, rd, e);
    apb(1'b0, `EDMI_IDX_TIMING, 8'h00, rd, e);
    check("timing rw", rd, 8'h5A);
  endtask : reset_values

  task automatic split_modes();
    cfg(8'h00, 5'b1_00_00, 8'h40);
    access(1'b0, 16'h0000, 8'h34, 1'b0, 16'h4034, 1'b0);
    cfg(8'h00, 5'b1_01_00, 8'h30);
    access(1'b0, 16'h0000, 8'h12, 1'b1, 16'hFF12, 1'b0);
    access(1'b1, 16'h2000, 8'h00, 1'b1, 16'h2000, 1'b1);
    access(1'b1, 16'h1FFF, 8'h00, 1'b0, 16'h1FFF, 1'b0);
    cfg(8'h00, 5'b1_01_00, 8'h1F);
    access(1'b0, 16'h0000, 8'h12, 1'b0, 16'h1F12, 1'b0);
    cfg(8'h00, 5'b1_10_00, 8'h40);
    access(1'b0, 16'h0000, 8'h56, 1'b1, 16'h4056, 1'b1);
    cfg(8'h00, 5'b1_10_00, 8'h20);
    access(1'b0, 16'h0000, 8'h01, 1'b1, 16'h2001, 1'b1);
  endtask : split_modes

  task automatic ext_only();
    cfg(8'h00, 5'b1_11_00, 8'h40);
    access(1'b0, 16'h0000, 8'h77, 1'b1, 16'hFF77, 1'b0);
    access(1'b1, 16'h0010, 8'h00, 1'b1, 16'h0010, 1'b1);
  endtask : ext_only

  task automatic timing_sweep();
    logic [7:0] tv [7] = '{8'hFF, 8'h00, 8'h40, 8'hC0, 8'h3C, 8'h03, 8'h55};
    foreach (tv[i]) begin
      cfg(tv[i], 5'b1_11_00, 8'h00);
      slow <= (tv[i][5:2] != 4'h0);
      access(1'b1, 16'h8000 + 16'(i), 8'h00, 1'b1, 16'h8000 + 16'(i), 1'b1);
    end
    slow <= 1'b0;
  endtask : timing_sweep

  task automatic mux_sweep();
    for (int a = 0; a < 4; a++) begin
      cfg(8'h00, {3'b011, a[1:0]}, 8'h00);
      access(1'b1, 16'h9000 + 16'(a), 8'h00, 1'b1, 16'h9000 + 16'(a), 1'b1);
    end
    cfg(8'h04, 5'b0_10_01, 8'h40);
    access(1'b0, 16'h0000, 8'h21, 1'b1, 16'h4021, 1'b1);
  endtask : mux_sweep

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    move_req = 1'b0;
    move_cmd = '0;
    slow = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    reset_values();
    split_modes();
    ext_only();
    timing_sweep();
    mux_sweep();
    print_verdict();
  end
endmodule : testbench

bind edmi_top edmi_props u_props (.clk_sys(clk_sys), .rstn(rstn), .move_done(move_done), .move_rdata(move_rdata),
  .pins_claimed(pins_claimed), .addr_hi_oe(addr_hi_oe), .addr_lo_oe(addr_lo_oe), .data_oe(data_oe),
  .data_i(data_i), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ctrl_oe(ctrl_oe));
